// File: src/pifb_defs.svh
`ifndef PIFB_DEFS_SVH
`define PIFB_DEFS_SVH

// Register byte offsets.
`define PIFB_OFS_ENABLE4   8'h00
`define PIFB_OFS_FLAG1     8'h04
`define PIFB_OFS_CORE_CTRL 8'h08
`define PIFB_OFS_STATUS    8'h0C

// Reset values.
`define PIFB_RST_ENABLE4   8'h00
`define PIFB_RST_FLAG1     8'h00
`define PIFB_RST_CORE_CTRL 2'h0

// Software-writable bit masks.
`define PIFB_EN4_SW_MASK   8'hCF
`define PIFB_FLAG1_SW_MASK 8'hCF

// Enable bank 4 bit positions.
`define PIFB_BIT_CAPCMP10_IRQ_EN           7
`define PIFB_BIT_CAPCMP9_IRQ_EN            6
`define PIFB_BIT_SERIAL2_RX_IRQ_EN         5
`define PIFB_BIT_SERIAL2_TX_IRQ_EN         4
`define PIFB_BIT_CAPCMP8_IRQ_EN            3
`define PIFB_BIT_CAPCMP7_IRQ_EN            2
`define PIFB_BIT_SYNCPORT2_COLLISION_IRQ_EN 1
`define PIFB_BIT_SYNCPORT2_IRQ_EN          0

// Core control register bit positions.
`define PIFB_BIT_GLOBAL_IRQ_ENABLE     7
`define PIFB_BIT_PERIPHERAL_IRQ_ENABLE 6

// Status register bit positions.
`define PIFB_BIT_STAT_REQ      0
`define PIFB_BIT_STAT_CORE_IRQ 1

// Bus responses.
`define PIFB_RESP_OKAY   2'h0
`define PIFB_RESP_SLVERR 2'h2

`endif

// File: src/pifb_flag_bank.sv
`timescale 1ns/1ps
`include "pifb_defs.svh"

module pifb_flag_bank #(
  parameter int               WIDTH   = 8,
  parameter logic [WIDTH-1:0] SW_MASK = `PIFB_FLAG1_SW_MASK,
  parameter logic [WIDTH-1:0] RST_VAL = `PIFB_RST_FLAG1
) (
  // Clock and reset.
  input wire logic    clk_sys,
  input wire logic    rst_n,
  // Flag access.
  pifb_flag_if.bank   flags
);

  logic [WIDTH-1:0] flag_q;
  logic [WIDTH-1:0] flag_d;

  // An event in the cycle of a software clear still sets the flag.
  // One continuous assignment per bit keeps each bit of flag_d to a single
  // driver without several processes writing one vector.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    if (SW_MASK[i]) begin : g_rw
      assign flag_d[i] = flags.evt[i]
                       | (flags.wr ? flags.wdata[i] : flag_q[i]);
    end else begin : g_ro
      assign flag_d[i] = flags.lvl[i];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= RST_VAL;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flags.q = flag_q;

endmodule

// File: src/pifb_flag_if.sv
`timescale 1ns/1ps

interface pifb_flag_if #(
  parameter int WIDTH = 8
);
  logic [WIDTH-1:0] evt;
  logic [WIDTH-1:0] lvl;
  logic             wr;
  logic [WIDTH-1:0] wdata;
  logic [WIDTH-1:0] q;

  modport bank (
    input  evt,
    input  lvl,
    input  wr,
    input  wdata,
    output q
  );

  modport ctrl (
    output evt,
    output lvl,
    output wr,
    output wdata,
    input  q
  );
endinterface

// File: src/pifb_pkg.sv
package pifb_pkg;

  typedef enum logic [2:0] {
    PIFB_SEL_ENABLE4,
    PIFB_SEL_FLAG1,
    PIFB_SEL_CORE_CTRL,
    PIFB_SEL_STATUS,
    PIFB_SEL_NONE
  } pifb_reg_sel_t;

  typedef enum logic {
    PIFB_WR_IDLE,
    PIFB_WR_RESP
  } pifb_wr_state_t;

  typedef enum logic {
    PIFB_RD_IDLE,
    PIFB_RD_DATA
  } pifb_rd_state_t;

endpackage

// File: src/pifb_top.sv
`timescale 1ns/1ps
`include "pifb_defs.svh"

// Functional notes
// - Enable bank 4 holds eight enables, bit 7 to 0: capcmp10, capcmp9, serial2 rx, serial2 tx, capcmp8, capcmp7, syncport2 collision, syncport2.
// - An enable bit at one lets its source interrupt, at zero it blocks it.
// - Enable bits 5 and 4 are read-only, reset to zero, and ignore writes.
// - Enable bits 1 and 0 are the syncport2 collision and syncport2 enables, readable and writable.
// - Flag bank 1 holds eight flags, bit 7 to 0: timer1 gate, adc done, serial1 rx, serial1 tx, syncport1, capcmp1, timer2 match, timer1 overflow.
// - A flag reads one while its interrupt is pending and zero otherwise.
// - Flags 5 and 4 are read-only and follow the hardware alone; the rest are writable.
// - A flag is set by its event regardless of its enable or the global enable.
// - Every enable and flag bit resets to zero on any reset.
// - No peripheral interrupt reaches the core unless the peripheral enable is set.
module pifb_top #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // AXI4-Lite write address.
  input  wire logic [ADDR_W-1:0] s_axil_awaddr,
  input  wire logic [2:0]        s_axil_awprot,
  input  wire logic              s_axil_awvalid,
  output logic                   s_axil_awready,
  // AXI4-Lite write data.
  input  wire logic [DATA_W-1:0] s_axil_wdata,
  input  wire logic [DATA_W/8-1:0] s_axil_wstrb,
  input  wire logic              s_axil_wvalid,
  output logic                   s_axil_wready,
  // AXI4-Lite write response.
  output logic [1:0]             s_axil_bresp,
  output logic                   s_axil_bvalid,
  input  wire logic              s_axil_bready,
  // AXI4-Lite read address.
  input  wire logic [ADDR_W-1:0] s_axil_araddr,
  input  wire logic [2:0]        s_axil_arprot,
  input  wire logic              s_axil_arvalid,
  output logic                   s_axil_arready,
  // AXI4-Lite read data.
  output logic [DATA_W-1:0]      s_axil_rdata,
  output logic [1:0]             s_axil_rresp,
  output logic                   s_axil_rvalid,
  input  wire logic              s_axil_rready,
  // Peripheral event sources.
  input  wire logic [7:0]        flag1_evt,
  input  wire logic [7:0]        flag1_lvl,
  input  wire logic [7:0]        flag4_in,
  input  wire logic [7:0]        enable1_in,
  // Register views and interrupt outputs.
  output logic [7:0]             enable4_out,
  output logic [7:0]             flag1_out,
  output logic                   periph_irq_req,
  output logic                   core_irq
);

  function automatic pifb_pkg::pifb_reg_sel_t
    addr_decode(input logic [ADDR_W-1:0] a);
    logic [7:0] w;
    w = {a[7:2], 2'h0};
    if ((a >> 8) != '0) begin
      addr_decode = pifb_pkg::PIFB_SEL_NONE;
    end else begin
      case (w)
        `PIFB_OFS_ENABLE4:   addr_decode = pifb_pkg::PIFB_SEL_ENABLE4;
        `PIFB_OFS_FLAG1:     addr_decode = pifb_pkg::PIFB_SEL_FLAG1;
        `PIFB_OFS_CORE_CTRL: addr_decode = pifb_pkg::PIFB_SEL_CORE_CTRL;
        `PIFB_OFS_STATUS:    addr_decode = pifb_pkg::PIFB_SEL_STATUS;
        default:             addr_decode = pifb_pkg::PIFB_SEL_NONE;
      endcase
    end
  endfunction

  pifb_flag_if #(.WIDTH(8)) flag1_bus ();

  pifb_flag_bank #(
    .WIDTH   (8),
    .SW_MASK (`PIFB_FLAG1_SW_MASK),
    .RST_VAL (`PIFB_RST_FLAG1)
  ) u_flag1 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .flags   (flag1_bus.bank)
  );

  // Write channel state.
  pifb_pkg::pifb_wr_state_t wst_q;
  pifb_pkg::pifb_wr_state_t wst_d;
  logic                     aw_got_q;
  logic                     aw_got_d;
  logic                     w_got_q;
  logic                     w_got_d;
  logic [ADDR_W-1:0]        awaddr_q;
  logic [ADDR_W-1:0]        awaddr_d;
  logic [7:0]               wbyte_q;
  logic [7:0]               wbyte_d;
  logic                     wlane_q;
  logic                     wlane_d;
  logic [1:0]               bresp_q;
  logic [1:0]               bresp_d;

  // Read channel state.
  pifb_pkg::pifb_rd_state_t rst_q;
  pifb_pkg::pifb_rd_state_t rst_d;
  logic [DATA_W-1:0]        rdata_q;
  logic [DATA_W-1:0]        rdata_d;
  logic [1:0]               rresp_q;
  logic [1:0]               rresp_d;

  // Block state.
  logic [7:0]               en4_q;
  logic [7:0]               en4_d;
  logic [1:0]               ctrl_q;
  logic [1:0]               ctrl_d;
  logic                     req_q;
  logic                     req_d;
  logic                     core_q;
  logic                     core_d;

  // Write decode.
  logic                     aw_hs;
  logic                     w_hs;
  logic                     do_write;
  logic [ADDR_W-1:0]        wr_addr;
  logic [7:0]               wr_byte;
  logic                     wr_lane;
  pifb_pkg::pifb_reg_sel_t  wr_sel;
  pifb_pkg::pifb_reg_sel_t  rd_sel;
  logic                     ar_hs;

  assign s_axil_awready = (wst_q == pifb_pkg::PIFB_WR_IDLE) & ~aw_got_q;
  assign s_axil_wready  = (wst_q == pifb_pkg::PIFB_WR_IDLE) & ~w_got_q;
  assign s_axil_bvalid  = (wst_q == pifb_pkg::PIFB_WR_RESP);
  assign s_axil_bresp   = bresp_q;
  assign s_axil_arready = (rst_q == pifb_pkg::PIFB_RD_IDLE);
  assign s_axil_rvalid  = (rst_q == pifb_pkg::PIFB_RD_DATA);
  assign s_axil_rdata   = rdata_q;
  assign s_axil_rresp   = rresp_q;

  assign aw_hs   = s_axil_awvalid & s_axil_awready;
  assign w_hs    = s_axil_wvalid & s_axil_wready;
  assign ar_hs   = s_axil_arvalid & s_axil_arready;
  assign wr_addr = aw_got_q ? awaddr_q : s_axil_awaddr;
  assign wr_byte = w_got_q ? wbyte_q : s_axil_wdata[7:0];
  assign wr_lane = w_got_q ? wlane_q : s_axil_wstrb[0];
  assign wr_sel  = addr_decode(wr_addr);
  assign rd_sel  = addr_decode(s_axil_araddr);

  // Address and data are taken in either order; the write lands once
  // both are held, so a lone half never disturbs a register.
  always_comb begin
    wst_d    = wst_q;
    aw_got_d = aw_got_q;
    w_got_d  = w_got_q;
    awaddr_d = awaddr_q;
    wbyte_d  = wbyte_q;
    wlane_d  = wlane_q;
    bresp_d  = bresp_q;
    do_write = 1'b0;
    case (wst_q)
      pifb_pkg::PIFB_WR_IDLE: begin
        if (aw_hs) begin
          aw_got_d = 1'b1;
          awaddr_d = s_axil_awaddr;
        end
        if (w_hs) begin
          w_got_d = 1'b1;
          wbyte_d = s_axil_wdata[7:0];
          wlane_d = s_axil_wstrb[0];
        end
        if ((aw_got_q | aw_hs) & (w_got_q | w_hs)) begin
          do_write = wr_lane;
          aw_got_d = 1'b0;
          w_got_d  = 1'b0;
          wst_d    = pifb_pkg::PIFB_WR_RESP;
          if (wr_sel == pifb_pkg::PIFB_SEL_NONE) begin
            bresp_d = `PIFB_RESP_SLVERR;
          end else begin
            bresp_d = `PIFB_RESP_OKAY;
          end
        end
      end
      pifb_pkg::PIFB_WR_RESP: begin
        if (s_axil_bready) begin
          wst_d = pifb_pkg::PIFB_WR_IDLE;
        end
      end
      default: begin
        wst_d = pifb_pkg::PIFB_WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wst_q    <= pifb_pkg::PIFB_WR_IDLE;
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      awaddr_q <= '0;
      wbyte_q  <= 8'h00;
      wlane_q  <= 1'b0;
      bresp_q  <= `PIFB_RESP_OKAY;
    end else begin
      wst_q    <= wst_d;
      aw_got_q <= aw_got_d;
      w_got_q  <= w_got_d;
      awaddr_q <= awaddr_d;
      wbyte_q  <= wbyte_d;
      wlane_q  <= wlane_d;
      bresp_q  <= bresp_d;
    end
  end

  // Register writes and interrupt request.
  always_comb begin
    en4_d  = en4_q;
    ctrl_d = ctrl_q;
    if (do_write && wr_sel == pifb_pkg::PIFB_SEL_ENABLE4) begin
      en4_d = (wr_byte & `PIFB_EN4_SW_MASK)
            | (en4_q & ~`PIFB_EN4_SW_MASK);
    end
    if (do_write && wr_sel == pifb_pkg::PIFB_SEL_CORE_CTRL) begin
      ctrl_d = {wr_byte[`PIFB_BIT_GLOBAL_IRQ_ENABLE],
                wr_byte[`PIFB_BIT_PERIPHERAL_IRQ_ENABLE]};
    end
    // A flag counts only where its own enable is one.
    req_d  = |(en4_q & flag4_in) | |(flag1_bus.q & enable1_in);
    // Read as bit 1 global, bit 0 peripheral.
    core_d = req_d & ctrl_d[1] & ctrl_d[0];
  end

  assign flag1_bus.evt   = flag1_evt;
  assign flag1_bus.lvl   = flag1_lvl;
  assign flag1_bus.wr    = do_write & (wr_sel == pifb_pkg::PIFB_SEL_FLAG1);
  assign flag1_bus.wdata = wr_byte;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en4_q  <= `PIFB_RST_ENABLE4;
      ctrl_q <= `PIFB_RST_CORE_CTRL;
      req_q  <= 1'b0;
      core_q <= 1'b0;
    end else begin
      en4_q  <= en4_d;
      ctrl_q <= ctrl_d;
      req_q  <= req_d;
      core_q <= core_d;
    end
  end

  // Read channel; data is captured at the address handshake.
  always_comb begin
    rst_d   = rst_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    case (rst_q)
      pifb_pkg::PIFB_RD_IDLE: begin
        if (ar_hs) begin
          rst_d   = pifb_pkg::PIFB_RD_DATA;
          rresp_d = `PIFB_RESP_OKAY;
          rdata_d = '0;
          case (rd_sel)
            pifb_pkg::PIFB_SEL_ENABLE4: begin
              rdata_d[7:0] = en4_q;
            end
            pifb_pkg::PIFB_SEL_FLAG1: begin
              rdata_d[7:0] = flag1_bus.q;
            end
            pifb_pkg::PIFB_SEL_CORE_CTRL: begin
              rdata_d[`PIFB_BIT_GLOBAL_IRQ_ENABLE]     = ctrl_q[1];
              rdata_d[`PIFB_BIT_PERIPHERAL_IRQ_ENABLE] = ctrl_q[0];
            end
            pifb_pkg::PIFB_SEL_STATUS: begin
              rdata_d[`PIFB_BIT_STAT_REQ]      = req_q;
              rdata_d[`PIFB_BIT_STAT_CORE_IRQ] = core_q;
            end
            default: begin
              rresp_d = `PIFB_RESP_SLVERR;
            end
          endcase
        end
      end
      pifb_pkg::PIFB_RD_DATA: begin
        if (s_axil_rready) begin
          rst_d = pifb_pkg::PIFB_RD_IDLE;
        end
      end
      default: begin
        rst_d = pifb_pkg::PIFB_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_q   <= pifb_pkg::PIFB_RD_IDLE;
      rdata_q <= '0;
      rresp_q <= `PIFB_RESP_OKAY;
    end else begin
      rst_q   <= rst_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // Software is expected to clear a stale flag before enabling it; the
  // hardware does not filter a flag that was pending beforehand.
  assign enable4_out    = en4_q;
  assign flag1_out      = flag1_bus.q;
  assign periph_irq_req = req_q;
  assign core_irq       = core_q;

endmodule

// File: verif/pifb_periph_model.sv
`timescale 1ns/1ps

module pifb_periph_model (
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Requests from the bench.
  input  wire logic [7:0] fire,
  input  wire logic [7:0] level,
  // Lines into the block.
  output logic      [7:0] flag1_evt,
  output logic      [7:0] flag1_lvl
);
  logic [7:0] evt_d;
  logic [7:0] lvl_d;
  // Bits 5 and 4 belong to the serial port as levels, never as pulses.
  always_comb begin
    evt_d = fire & 8'hCF;
    lvl_d = level & 8'h30;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag1_evt <= 8'h00;
      flag1_lvl <= 8'h00;
    end else begin
      flag1_evt <= evt_d;
      flag1_lvl <= lvl_d;
    end
  end
endmodule

// File: verif/pifb_top_monitor.sv
`timescale 1ns/1ps
`include "pifb_defs.svh"

module pifb_top_monitor #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  // Clock and reset.
  input wire logic                clk_sys,
  input wire logic                rst_n,
  // Bus.
  input wire logic [ADDR_W-1:0]   s_axil_awaddr,
  input wire logic                s_axil_awvalid,
  input wire logic                s_axil_awready,
  input wire logic [DATA_W-1:0]   s_axil_wdata,
  input wire logic [DATA_W/8-1:0] s_axil_wstrb,
  input wire logic                s_axil_wvalid,
  input wire logic                s_axil_wready,
  input wire logic [1:0]          s_axil_bresp,
  input wire logic                s_axil_bvalid,
  input wire logic                s_axil_arvalid,
  input wire logic                s_axil_arready,
  input wire logic                s_axil_rvalid,
  // Events and outputs.
  input wire logic [7:0]          flag1_evt,
  input wire logic [7:0]          flag1_lvl,
  input wire logic [7:0]          flag4_in,
  input wire logic [7:0]          enable1_in,
  input wire logic [7:0]          enable4_out,
  input wire logic [7:0]          flag1_out,
  input wire logic                periph_irq_req,
  input wire logic                core_irq
);
  localparam logic [7:0] RW_MASK = 8'hCF;
  logic wr_both;
  logic wr_en;
  logic wr_fl;
  // Only writes whose halves arrive together are judged here.
  assign wr_both = s_axil_awvalid && s_axil_awready &&
                   s_axil_wvalid && s_axil_wready;
  assign wr_en = wr_both && s_axil_wstrb[0] &&
                 s_axil_awaddr == `PIFB_OFS_ENABLE4;
  assign wr_fl = wr_both && s_axil_wstrb[0] &&
                 s_axil_awaddr == `PIFB_OFS_FLAG1;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_en_ro_zero: assert property (enable4_out[5:4] == 2'h0)
    else $error("enable bits 5 and 4 not zero");
  a_evt_sets_flag: assert property (|(flag1_evt & RW_MASK) |=>
    (flag1_out & $past(flag1_evt & RW_MASK)) == $past(flag1_evt & RW_MASK))
    else $error("event did not set its flag");
  a_lvl_follow: assert property ($past(rst_n) |->
    flag1_out[5:4] == $past(flag1_lvl[5:4]))
    else $error("serial flags do not follow levels");
  a_flag_store: assert property (wr_fl && !(|(flag1_evt & RW_MASK)) |=>
    (flag1_out & RW_MASK) == ($past(s_axil_wdata[7:0]) & RW_MASK))
    else $error("flag write not stored");
  a_en_store: assert property (wr_en |=>
    enable4_out == ($past(s_axil_wdata[7:0]) & RW_MASK))
    else $error("enable write not stored");
  a_req_gate: assert property ($past(rst_n) |-> periph_irq_req ==
    $past(|((enable4_out & flag4_in) | (flag1_out & enable1_in))))
    else $error("request does not match flags and enables");
  a_core_needs_req: assert property (core_irq |-> periph_irq_req)
    else $error("core interrupt without request");
  a_wr_resp: assert property (wr_both |=> s_axil_bvalid &&
    s_axil_bresp == ($past(s_axil_awaddr[ADDR_W-1:4] != 0) ?
    `PIFB_RESP_SLVERR : `PIFB_RESP_OKAY))
    else $error("write response wrong");
  a_rd_answer: assert property (s_axil_arvalid && s_axil_arready |=>
    s_axil_rvalid)
    else $error("read answer late");

  c_core: cover property (core_irq);
  c_flag_wr: cover property (wr_fl);
  c_evt: cover property (|(flag1_evt & RW_MASK));
endmodule

bind pifb_top pifb_top_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
  u_pifb_top_monitor (.*);

// File: verif/tb_pifb_top.sv
`timescale 1ns/1ps
`include "pifb_defs.svh"

module tb_pifb_top;
  localparam logic [7:0] RW = 8'hCF;
  logic        clk_sys, rst_n;
  logic [7:0]  s_axil_awaddr, s_axil_araddr;
  logic [2:0]  s_axil_awprot, s_axil_arprot;
  logic [31:0] s_axil_wdata, s_axil_rdata;
  logic [3:0]  s_axil_wstrb;
  logic [1:0]  s_axil_bresp, s_axil_rresp, rr;
  logic        s_axil_awvalid, s_axil_awready, s_axil_wvalid;
  logic        s_axil_wready, s_axil_bvalid, s_axil_bready;
  logic        s_axil_arvalid, s_axil_arready, s_axil_rvalid;
  logic        s_axil_rready, periph_irq_req, core_irq, e;
  logic [7:0]  flag1_evt, flag1_lvl, flag4_in, enable1_in;
  logic [7:0]  fire, level, enable4_out, flag1_out;
  logic [31:0] seed, d, rdat;
  int          err_count, samples_checked, i;

  pifb_top u_pifb_top (.*);
  pifb_periph_model u_pifb_periph_model (.*);

  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function logic req_exp(input logic [7:0] en, f4, f1, e1);
    return |((en & f4) | (f1 & e1));
  endfunction

  task automatic chk(input string nm, input logic [31:0] s, ex);
    samples_checked++;
    if (s !== ex) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    s_axil_awaddr <= a;
    s_axil_wdata <= v;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axil_awvalid && s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wvalid && s_axil_wready) s_axil_wvalid <= 1'b0;
    end while (!s_axil_bvalid);
    rr = s_axil_bresp;
    s_axil_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axil_arvalid && s_axil_arready) s_axil_arvalid <= 1'b0;
    end while (!s_axil_rvalid);
    rdat = s_axil_rdata;
    rr = s_axil_rresp;
    s_axil_rready <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] ex);
    rd(a);
    chk("rdata", rdat, {24'h000000, ex});
    chk("rresp", rr, `PIFB_RESP_OKAY);
  endtask

  // Four edges cover the model stage plus two register stages.
  task automatic settle();
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  initial begin
    repeat (6000) @(posedge clk_sys);
    err_count++;
    results();
  end

  initial begin
    seed = 32'h0000D039;
    {s_axil_awaddr, s_axil_araddr, s_axil_wdata, fire, level} = '0;
    {s_axil_awprot, s_axil_arprot, flag4_in, enable1_in} = '0;
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready} = '0;
    {s_axil_arvalid, s_axil_rready} = '0;
    s_axil_wstrb = 4'hF;
    err_count = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdchk(`PIFB_OFS_ENABLE4, 8'h00);
    rdchk(`PIFB_OFS_FLAG1, 8'h00);
    for (i = 0; i < 16; i++) begin
      d = (i == 0) ? 32'h0000FFFF : xs();
      wr(`PIFB_OFS_ENABLE4, d);
      flag4_in <= d[15:8];
      rdchk(`PIFB_OFS_ENABLE4, d[7:0] & RW);
      settle();
      e = req_exp(d[7:0] & RW, d[15:8], 8'h00, 8'h00);
      chk("req", periph_irq_req, e);
    end
    for (i = 0; i < 16; i++) begin
      d = (i == 0) ? 32'h00FF00FF : xs();
      @(posedge clk_sys);
      level <= d[23:16];
      wr(`PIFB_OFS_FLAG1, d);
      settle();
      rdchk(`PIFB_OFS_FLAG1, (d[7:0] & RW) | (d[23:16] & 8'h30));
    end
    @(posedge clk_sys);
    level <= 8'h00;
    flag4_in <= 8'h00;
    wr(`PIFB_OFS_ENABLE4, 32'h00000000);
    for (i = 0; i < 8; i++) begin
      wr(`PIFB_OFS_CORE_CTRL, 32'h00000000);
      wr(`PIFB_OFS_FLAG1, 32'h00000000);
      @(posedge clk_sys);
      enable1_in <= 8'h00;
      fire <= 8'h01 << i;
      @(posedge clk_sys);
      fire <= 8'h00;
      settle();
      chk("flag", flag1_out, (8'h01 << i) & RW);
      chk("req off", periph_irq_req, 1'b0);
      @(posedge clk_sys);
      enable1_in <= 8'h01 << i;
      wr(`PIFB_OFS_CORE_CTRL, 32'h00000080);
      settle();
      e = req_exp(8'h00, 8'h00, (8'h01 << i) & RW, 8'h01 << i);
      chk("req on", periph_irq_req, e);
      chk("core gated", core_irq, 1'b0);
      wr(`PIFB_OFS_CORE_CTRL, 32'h000000C0);
      settle();
      chk("core", core_irq, e);
      rdchk(`PIFB_OFS_CORE_CTRL, 8'hC0);
      rdchk(`PIFB_OFS_STATUS, {6'h00, e, e});
      wr(`PIFB_OFS_FLAG1, 32'h00000000);
      settle();
      chk("req clear", periph_irq_req, 1'b0);
    end
    wr(8'h10, 32'h000000FF);
    chk("bresp unmapped", rr, `PIFB_RESP_SLVERR);
    rd(8'h10);
    chk("rresp unmapped", rr, `PIFB_RESP_SLVERR);
    chk("rdata unmapped", rdat, 32'h00000000);
    // A write without byte lane 0 is answered but changes nothing.
    s_axil_wstrb <= 4'hE;
    wr(`PIFB_OFS_ENABLE4, 32'h000000FF);
    s_axil_wstrb <= 4'hF;
    chk("bresp lane", rr, `PIFB_RESP_OKAY);
    rdchk(`PIFB_OFS_ENABLE4, 8'h00);
    wr(`PIFB_OFS_ENABLE4, 32'h000000FF);
    wr(`PIFB_OFS_FLAG1, 32'h000000FF);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdchk(`PIFB_OFS_ENABLE4, 8'h00);
    rdchk(`PIFB_OFS_FLAG1, 8'h00);
    results();
  end
endmodule
